// ===== pkg/mmsi_defines.svh
// Purpose: Constants of the multi-mode serial interface.
// Assumes: Included by its bare name; mclk runs at 10 MHz.
// Notes: Mode codes and divider figures are used by the logic only; the bench sets its own.
`ifndef MMSI_DEFINES_SVH
`define MMSI_DEFINES_SVH

`define MMSI_MCLK_HZ 10000000
`define MMSI_OSC_HZ 75000
// Oscillator enable period in mclk cycles, rounded down
`define MMSI_OSC_DIV (`MMSI_MCLK_HZ / `MMSI_OSC_HZ)
// UART bit length in oscillator ticks (fosc/8)
`define MMSI_UART_OSC_PER_BIT 8'h08
`define MMSI_UART_HALF_BIT 8'h04
// Mode field codes
`define MMSI_MODE_THREE 2'h0
`define MMSI_MODE_TWO 2'h1
`define MMSI_MODE_UART 2'h2
// Channel select codes
`define MMSI_CH_PUSH_PULL 1'h0
`define MMSI_CH_OPEN_DRAIN 1'h1
// Pin index within the six-bit pin vector: channel * 3 + offset
`define MMSI_PIN_CLK 3'h0
`define MMSI_PIN_DAT 3'h1
`define MMSI_PIN_RX 3'h2
// Reset values
`define MMSI_RST_OE_N 2'h3
`define MMSI_RST_LINE 1'h1

`endif

// ===== pkg/mmsi_pkg.sv
// Purpose: Types of the multi-mode serial interface.
// Assumes: Constants live in mmsi_defines.svh.
// Notes: Engine and receiver states are separate enums.
package mmsi_pkg;

	typedef enum logic [2:0] {E_IDLE, E_SYNC, U_START, U_DATA, U_STOP} mmsi_eng_t;
	typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} mmsi_rx_t;

	typedef struct packed {
		logic serial_pin_enable;
		logic port_sel;
		logic clock_idle_level_select;
		logic open_drain_select;
		logic halt_counter_select;
		logic data_pin_direction;
		logic msb_first;
		logic master_select;
		logic mode_bit_high;
		logic mode_bit_low;
		logic [1:0] divider_sel;
		logic [1:0] rate_sel;
		logic [3:0] begin_position_field;
		logic [3:0] end_position_field;
		logic [15:0] transmit_data_field;
	} mmsi_ctrl_t;

	typedef struct packed {
		logic clock_active_flag;
		logic link_active_flag;
		logic transmit_error_flag;
		logic [3:0] receive_bit_counter;
		logic [3:0] transmit_bit_counter;
		logic [15:0] receive_data_field;
	} mmsi_stat_t;

	typedef struct packed {
		logic [5:0] s1;
		logic [5:0] s2;
		logic [5:0] s3;
		logic [5:0] filt;
		logic prev_clk;
		logic prev_rx;
		logic [7:0] osc_cnt;
		logic [7:0] half_cnt;
		logic [7:0] rx_cnt;
		mmsi_eng_t st;
		mmsi_rx_t rst_st;
		logic sclk;
		logic [3:0] out_cnt;
		logic [3:0] in_cnt;
		logic [15:0] rx_data;
		logic clock_act;
		logic link_act;
		logic err;
		logic irq;
		logic [1:0] ck_out;
		logic [1:0] ck_oe_n;
		logic [1:0] dt_out;
		logic [1:0] dt_oe_n;
	} mmsi_state_t;

endpackage : mmsi_pkg

// ===== src/mmsi_top.sv
// Purpose: One serial engine for three-wire, two-wire and UART links on two pin channels.
// Assumes: 10 MHz mclk; 75 kHz oscillator made by an enable divider.
// Notes: Pin outputs lag the engine by one mclk; oe_n low means the pin is driven.
`timescale 1ns/1ps
`include "mmsi_defines.svh"

module mmsi_top #(
	parameter int OSC_DIV = `MMSI_OSC_DIV
) (
	input wire logic mclk,
	input wire logic rst,
	input wire mmsi_pkg::mmsi_ctrl_t ctrl,
	input wire logic master_start_trigger,
	output mmsi_pkg::mmsi_stat_t stat,
	output logic serial_irq,
	input wire logic ch1_clock_tx_pin_in,
	output logic ch1_clock_tx_pin_out,
	output logic ch1_clock_tx_pin_oe_n,
	input wire logic ch1_bidir_data_pin_in,
	output logic ch1_bidir_data_pin_out,
	output logic ch1_bidir_data_pin_oe_n,
	input wire logic ch1_rx_pin,
	input wire logic ch2_clock_tx_pin_in,
	output logic ch2_clock_tx_pin_out,
	output logic ch2_clock_tx_pin_oe_n,
	input wire logic ch2_bidir_data_pin_in,
	output logic ch2_bidir_data_pin_out,
	output logic ch2_bidir_data_pin_oe_n,
	input wire logic ch2_rx_pin
);

	if (OSC_DIV < 2 || OSC_DIV > 255) begin : g_bad_div
		$error("mmsi_top: OSC_DIV must lie in 2..255");
	end

	mmsi_pkg::mmsi_state_t r;
	mmsi_pkg::mmsi_state_t n;

	logic [5:0] pins;
	logic osc_tick;
	logic [1:0] mode;
	logic is_sync;
	logic is_master;
	logic [2:0] shamt;
	logic [7:0] half_lim;
	logic [7:0] bit_lim;
	logic [7:0] mid_lim;
	logic bit_tick;
	logic clk_now;
	logic lead_ev;
	logic trail_ev;
	logic rx_bit;
	logic uart_rx_in;
	logic [3:0] step;
	logic [3:0] gov;
	logic start_ok;
	logic ch_od;
	logic line;
	logic drive_ck;
	logic drive_dt;
	logic dt_val;

	assign pins = {ch2_rx_pin, ch2_bidir_data_pin_in, ch2_clock_tx_pin_in,
		ch1_rx_pin, ch1_bidir_data_pin_in, ch1_clock_tx_pin_in};
	assign mode = {ctrl.mode_bit_high, ctrl.mode_bit_low};
	assign is_sync = (mode == `MMSI_MODE_THREE) || (mode == `MMSI_MODE_TWO);
	assign is_master = ctrl.master_select && is_sync;
	assign osc_tick = (r.osc_cnt == 8'(OSC_DIV - 1));
	// Half period in oscillator ticks: /2 -> 1, /4 -> 2, /8 -> 4, scaled by rate select
	assign shamt = ((ctrl.divider_sel == 2'h3) ? 3'h2 : {1'h0, ctrl.divider_sel})
		+ {1'h0, ctrl.rate_sel};
	assign half_lim = (8'h01 << shamt) - 8'h01;
	assign bit_lim = (`MMSI_UART_OSC_PER_BIT << ctrl.rate_sel) - 8'h01;
	assign mid_lim = (`MMSI_UART_HALF_BIT << ctrl.rate_sel) - 8'h01;
	assign bit_tick = osc_tick && (r.half_cnt == (is_sync ? half_lim : bit_lim));
	assign clk_now = r.filt[3 * ctrl.port_sel + `MMSI_PIN_CLK];
	assign uart_rx_in = r.filt[3 * ctrl.port_sel + `MMSI_PIN_RX];
	// Three-wire reads the dedicated input; two-wire reads the bidirectional pin
	assign rx_bit = (mode == `MMSI_MODE_THREE) ? uart_rx_in
		: r.filt[3 * ctrl.port_sel + `MMSI_PIN_DAT];
	assign step = ctrl.msb_first ? 4'hf : 4'h1;
	assign gov = ctrl.halt_counter_select ? r.in_cnt : r.out_cnt;
	assign start_ok = master_start_trigger && ctrl.serial_pin_enable && (r.st == mmsi_pkg::E_IDLE);
	// Master edges come from our own toggles, slave edges from the filtered pin
	always_comb begin
		if (is_master) begin
			lead_ev = (r.st == mmsi_pkg::E_SYNC) && bit_tick && (r.sclk == ctrl.clock_idle_level_select);
			trail_ev = (r.st == mmsi_pkg::E_SYNC) && bit_tick && (r.sclk != ctrl.clock_idle_level_select);
		end else begin
			lead_ev = (r.st == mmsi_pkg::E_SYNC) && (clk_now != r.prev_clk)
				&& (clk_now != ctrl.clock_idle_level_select);
			trail_ev = (r.st == mmsi_pkg::E_SYNC) && (clk_now != r.prev_clk)
				&& (clk_now == ctrl.clock_idle_level_select);
		end
	end

	always_comb begin
		n = r;
		n.irq = 1'h0;
		n.s1 = pins;
		n.s2 = r.s1;
		n.s3 = r.s2;
		// A pin change counts only once the last two stages agree
		n.filt = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.filt);
		n.prev_clk = clk_now;
		n.prev_rx = uart_rx_in;
		n.osc_cnt = osc_tick ? 8'h00 : r.osc_cnt + 8'h01;
		if (osc_tick) begin
			n.half_cnt = bit_tick ? 8'h00 : r.half_cnt + 8'h01;
		end
		if (master_start_trigger && !start_ok) begin
			n.err = 1'h1;
		end
		case (r.st)
			mmsi_pkg::E_IDLE: begin
				n.sclk = ctrl.clock_idle_level_select;
				if (start_ok && mode != 2'h3) begin
					n.out_cnt = ctrl.begin_position_field;
					n.in_cnt = ctrl.begin_position_field;
					n.half_cnt = 8'h00;
					n.err = 1'h0;
					n.st = is_sync ? mmsi_pkg::E_SYNC : mmsi_pkg::U_START;
				end
			end
			mmsi_pkg::E_SYNC: begin
				if (is_master && bit_tick) begin
					n.sclk = ~r.sclk;
				end
				if (trail_ev) begin
					n.rx_data[r.in_cnt] = rx_bit;
					if (gov == ctrl.end_position_field) begin
						n.st = mmsi_pkg::E_IDLE;
						n.irq = 1'h1;
					end else begin
						n.out_cnt = r.out_cnt + step;
						n.in_cnt = r.in_cnt + step;
					end
				end
				if (!is_sync) begin
					n.st = mmsi_pkg::E_IDLE;
				end
			end
			mmsi_pkg::U_START: begin
				if (bit_tick) begin
					n.st = mmsi_pkg::U_DATA;
				end
			end
			mmsi_pkg::U_DATA: begin
				if (bit_tick) begin
					if (r.out_cnt == ctrl.end_position_field) begin
						n.st = mmsi_pkg::U_STOP;
					end else begin
						n.out_cnt = r.out_cnt + step;
					end
				end
			end
			mmsi_pkg::U_STOP: begin
				if (bit_tick) begin
					n.st = mmsi_pkg::E_IDLE;
					n.irq = 1'h1;
				end
			end
			default: n.st = mmsi_pkg::E_IDLE;
		endcase
		if (osc_tick && r.rst_st != mmsi_pkg::R_IDLE) begin
			n.rx_cnt = r.rx_cnt + 8'h01;
		end
		case (r.rst_st)
			mmsi_pkg::R_IDLE: begin
				if (mode == `MMSI_MODE_UART && ctrl.serial_pin_enable && r.prev_rx && !uart_rx_in) begin
					n.rst_st = mmsi_pkg::R_START;
					n.rx_cnt = 8'h00;
					n.in_cnt = ctrl.begin_position_field;
				end
			end
			mmsi_pkg::R_START: begin
				if (osc_tick && r.rx_cnt == mid_lim) begin
					n.rx_cnt = 8'h00;
					n.rst_st = uart_rx_in ? mmsi_pkg::R_IDLE : mmsi_pkg::R_DATA;
				end
			end
			mmsi_pkg::R_DATA: begin
				if (osc_tick && r.rx_cnt == bit_lim) begin
					n.rx_cnt = 8'h00;
					n.rx_data[r.in_cnt] = uart_rx_in;
					if (r.in_cnt == ctrl.end_position_field) begin
						n.rst_st = mmsi_pkg::R_STOP;
					end else begin
						n.in_cnt = r.in_cnt + step;
					end
				end
			end
			mmsi_pkg::R_STOP: begin
				if (osc_tick && r.rx_cnt == bit_lim) begin
					n.rst_st = mmsi_pkg::R_IDLE;
					n.irq = 1'h1;
					if (!uart_rx_in) begin
						n.err = 1'h1;
					end
				end
			end
			default: n.rst_st = mmsi_pkg::R_IDLE;
		endcase
		if (mode != `MMSI_MODE_UART) begin
			n.rst_st = mmsi_pkg::R_IDLE;
		end
		n.clock_act = (n.st != mmsi_pkg::E_IDLE);
		n.link_act = (n.st == mmsi_pkg::E_SYNC && mode == `MMSI_MODE_TWO)
			|| (n.rst_st != mmsi_pkg::R_IDLE);
		// Pin drive from the current engine state
		ch_od = ctrl.open_drain_select || (ctrl.port_sel == `MMSI_CH_OPEN_DRAIN);
		line = `MMSI_RST_LINE;
		drive_ck = 1'h0;
		if (mode == `MMSI_MODE_UART) begin
			drive_ck = 1'h1;
			line = (r.st == mmsi_pkg::U_START) ? 1'h0
				: (r.st == mmsi_pkg::U_DATA) ? ctrl.transmit_data_field[r.out_cnt] : 1'h1;
		end else if (is_master) begin
			drive_ck = 1'h1;
			line = r.sclk;
		end
		drive_dt = is_sync && ctrl.data_pin_direction;
		dt_val = ctrl.transmit_data_field[r.out_cnt];
		n.ck_out = 2'h0;
		n.dt_out = 2'h0;
		n.ck_oe_n = 2'h3;
		n.dt_oe_n = 2'h3;
		if (ctrl.serial_pin_enable) begin
			// Open-drain only pulls low; a high is left to the pull-up
			n.ck_out[ctrl.port_sel] = ch_od ? 1'h0 : line;
			n.ck_oe_n[ctrl.port_sel] = !(drive_ck && !(ch_od && line));
			n.dt_out[ctrl.port_sel] = ch_od ? 1'h0 : dt_val;
			n.dt_oe_n[ctrl.port_sel] = !(drive_dt && !(ch_od && dt_val));
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r <= '0;
			r.ck_oe_n <= `MMSI_RST_OE_N;
			r.dt_oe_n <= `MMSI_RST_OE_N;
		end else begin
			r <= n;
		end
	end

	assign stat = '{r.clock_act, r.link_act, r.err, r.in_cnt, r.out_cnt, r.rx_data};
	assign serial_irq = r.irq;
	assign ch1_clock_tx_pin_out = r.ck_out[0];
	assign ch1_clock_tx_pin_oe_n = r.ck_oe_n[0];
	assign ch1_bidir_data_pin_out = r.dt_out[0];
	assign ch1_bidir_data_pin_oe_n = r.dt_oe_n[0];
	assign ch2_clock_tx_pin_out = r.ck_out[1];
	assign ch2_clock_tx_pin_oe_n = r.ck_oe_n[1];
	assign ch2_bidir_data_pin_out = r.dt_out[1];
	assign ch2_bidir_data_pin_oe_n = r.dt_oe_n[1];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_clk_idle_level: assert property (
		r.st == mmsi_pkg::E_IDLE && $stable(ctrl.clock_idle_level_select)
		|=> r.sclk == $past(ctrl.clock_idle_level_select))
		else $error("shift clock not at idle level");
	a_start_trig: assert property (
		start_ok && is_master && mode != 2'h3 |=> r.st == mmsi_pkg::E_SYNC ##1 r.clock_act)
		else $error("trigger did not start clock");
	a_halt_stop: assert property (
		trail_ev && gov == ctrl.end_position_field |=> r.st == mmsi_pkg::E_IDLE && r.irq)
		else $error("transfer did not halt at stop position");
	a_ctr_load: assert property (
		start_ok && is_sync |=> r.out_cnt == $past(ctrl.begin_position_field)
		&& r.in_cnt == $past(ctrl.begin_position_field))
		else $error("counters not loaded with start position");
	a_ctr_order: assert property (
		trail_ev && gov != ctrl.end_position_field
		|=> r.out_cnt == $past(r.out_cnt) + $past(step))
		else $error("counter stepped the wrong way");
	a_od_low_only: assert property (
		!r.ck_oe_n[1] || !r.dt_oe_n[1] |-> r.ck_out[1] == 1'h0 && r.dt_out[1] == 1'h0)
		else $error("open-drain channel drove high");
	a_dir_input: assert property (
		!ctrl.data_pin_direction && $stable(ctrl.data_pin_direction) |=> &r.dt_oe_n)
		else $error("data pin driven while set as input");
	a_uart_start: assert property (
		r.st == mmsi_pkg::U_START && ctrl.serial_pin_enable && $stable(ctrl)
		&& mode == `MMSI_MODE_UART |=> r.ck_out[ctrl.port_sel] == 1'h0)
		else $error("UART start bit not low");
	a_busy_flag: assert property (
		$rose(r.st != mmsi_pkg::E_IDLE) |-> r.clock_act ##1 r.clock_act)
		else $error("clock-active flag missed running engine");

	c_master_done: cover property (r.st == mmsi_pkg::E_SYNC && is_master ##1 r.irq);
	c_slave_done: cover property (r.st == mmsi_pkg::E_SYNC && !is_master ##1 r.irq);
	c_uart_tx: cover property (r.st == mmsi_pkg::U_STOP ##1 r.st == mmsi_pkg::E_IDLE);
	c_uart_rx: cover property (r.rst_st == mmsi_pkg::R_STOP ##1 r.rst_st == mmsi_pkg::R_IDLE);

endmodule : mmsi_top

// ===== verif/mmsi_far_end.sv
// Purpose: Far-end shift partner for the synchronous links.
// Assumes: Clock and data inputs are resolved pin levels.
// Notes: Behavioural; follows the clock pin, not mclk.
`timescale 1ns/1ps
module mmsi_far_end (
	input wire logic sclk,
	input wire logic dat,
	input wire logic idle_lvl,
	input wire logic [15:0] pattern,
	input wire logic restart,
	output logic pbit,
	output logic [15:0] cap
);
	int k;
	int n;
	// Data and clock pins leave the same flop edge; sample the level held before it
	wire logic dat_late;
	assign #1 dat_late = dat;
	// Line shows the inverse before the first bit, never a stale value
	always @(posedge restart) begin
		k = 0;
		n = 0;
		pbit = ~pattern[0];
	end
	// Present on the leading edge, sample on the trailing edge
	always @(sclk) begin
		if (!restart && sclk !== idle_lvl) begin
			pbit = pattern[k % 16];
			k++;
		end else if (!restart && k > n) begin
			cap[n % 16] = dat_late;
			n++;
		end
	end
endmodule : mmsi_far_end

// ===== verif/mmsi_top_test.sv
// Purpose: Self-checking bench for the multi-mode serial interface.
// Assumes: OSC_DIV shortened to 2; pins resolved with pull-ups.
// Notes: Expected bits come from an integer index model of the counters.
`timescale 1ns/1ps
module mmsi_top_test;
	logic mclk, rst, trig, restart, pbit, serial_irq;
	logic [15:0] pattern, cap;
	mmsi_pkg::mmsi_ctrl_t ctrl;
	mmsi_pkg::mmsi_ctrl_t c;
	mmsi_pkg::mmsi_stat_t stat;
	logic k1o, k1e, d1o, d1e, k2o, k2e, d2o, d2e;
	int miscompares, samples_checked, cycles, t, j, n, b, e, i;
	wire logic k1 = k1e ? 1'b1 : k1o;
	wire logic k2 = k2e ? 1'b1 : k2o;
	// A released output data pin floats to its pull-up; partner drives only inputs
	wire logic d1 = d1e ? (ctrl.data_pin_direction ? 1'b1 : pbit) : d1o;
	wire logic d2 = d2e ? (ctrl.data_pin_direction ? 1'b1 : pbit) : d2o;
	wire logic sel = ctrl.port_sel;

	mmsi_top #(.OSC_DIV(2)) u_dut (.mclk(mclk), .rst(rst), .ctrl(ctrl),
		.master_start_trigger(trig), .stat(stat), .serial_irq(serial_irq),
		.ch1_clock_tx_pin_in(k1), .ch1_clock_tx_pin_out(k1o), .ch1_clock_tx_pin_oe_n(k1e),
		.ch1_bidir_data_pin_in(d1), .ch1_bidir_data_pin_out(d1o),
		.ch1_bidir_data_pin_oe_n(d1e), .ch1_rx_pin(sel ? ~pbit : pbit),
		.ch2_clock_tx_pin_in(k2), .ch2_clock_tx_pin_out(k2o), .ch2_clock_tx_pin_oe_n(k2e),
		.ch2_bidir_data_pin_in(d2), .ch2_bidir_data_pin_out(d2o),
		.ch2_bidir_data_pin_oe_n(d2e), .ch2_rx_pin(sel ? pbit : ~pbit));

	mmsi_far_end u_far (.sclk(sel ? k2 : k1), .dat(sel ? d2 : d1),
		.idle_lvl(ctrl.clock_idle_level_select), .pattern(pattern), .restart(restart),
		.pbit(pbit), .cap(cap));

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task tick(input int cnt);
		repeat (cnt) @(posedge mclk);
		#1;
	endtask : tick

	task pulse_start();
		@(posedge mclk);
		trig <= 1'b1;
		@(posedge mclk);
		trig <= 1'b0;
	endtask : pulse_start

	task wait_irq();
		int w;
		for (w = 0; w < 4000 && serial_irq !== 1'b1; w++) tick(1);
		chk(16'(w < 4000), 16'h1);
	endtask : wait_irq

	task setup(input logic [15:0] pat);
		@(posedge mclk);
		ctrl <= c;
		pattern <= pat;
		restart <= 1'b1;
		tick(2);
		restart <= 1'b0;
		b = c.begin_position_field;
		e = c.end_position_field;
		n = ((c.msb_first ? b - e : e - b) & 15) + 1;
	endtask : setup

	task give_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Hang guard sized well above the longest transfer sequence
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		rst = 1'b1;
		trig = 1'b0;
		restart = 1'b0;
		pattern = 16'h0;
		ctrl = '0;
		void'($urandom(32'h42fa83fc));
		tick(3);
		chk({12'h0, k1e, d1e, k2e, d2e}, 16'h000f);
		chk({13'h0, stat.clock_active_flag, stat.link_active_flag, serial_irq}, 16'h0);
		rst <= 1'b0;
		tick(5);
		for (t = 0; t < 8; t++) begin
			c = '0;
			c.serial_pin_enable = 1'b1;
			c.port_sel = $urandom;
			c.clock_idle_level_select = $urandom;
			c.open_drain_select = $urandom;
			c.halt_counter_select = $urandom;
			c.data_pin_direction = (t % 2 == 0);
			c.msb_first = $urandom;
			c.master_select = 1'b1;
			c.mode_bit_low = t % 2;
			c.divider_sel = 2'(t % 4);
			c.rate_sel = 2'h2;
			c.begin_position_field = $urandom;
			c.end_position_field = $urandom;
			c.transmit_data_field = $urandom;
			setup(16'($urandom));
			pulse_start();
			tick(2);
			chk(16'(stat.clock_active_flag), 16'h1);
			chk(16'(stat.link_active_flag), 16'(t % 2));
			chk(16'(stat.transmit_error_flag), 16'h0);
			pulse_start();
			tick(2);
			chk(16'(stat.transmit_error_flag), 16'h1);
			wait_irq();
			tick(3);
			chk(16'(stat.clock_active_flag), 16'h0);
			chk(16'(sel ? k2 : k1), 16'(c.clock_idle_level_select));
			chk(16'(sel ? k2e : k1e), 16'((c.open_drain_select | sel) ?
				c.clock_idle_level_select : 1'b0));
			chk(16'(sel ? k1e : k2e), 16'h1);
			chk(16'(stat.transmit_bit_counter), 16'(e));
			chk(16'(stat.receive_bit_counter), 16'(e));
			chk(16'(stat.link_active_flag), 16'h0);
			for (j = 0; j < n; j++) begin
				i = (b + (c.msb_first ? -j : j)) & 15;
				chk(16'(stat.receive_data_field[i]), 16'(pattern[j]));
				if (t % 2 == 0) chk(16'(cap[j]), 16'(c.transmit_data_field[i]));
			end
		end
		c.mode_bit_high = 1'b1;
		c.mode_bit_low = 1'b1;
		setup(16'h0);
		pulse_start();
		tick(3);
		chk(16'(stat.clock_active_flag), 16'h0);
		c.mode_bit_low = 1'b0;
		c.master_select = 1'b0;
		c.port_sel = 1'b0;
		c.open_drain_select = 1'b0;
		c.rate_sel = 2'h0;
		c.transmit_data_field = $urandom;
		setup(16'hffff);
		chk(16'(k1), 16'h1);
		pulse_start();
		for (i = 0; i < 300 && k1 !== 1'b0; i++) tick(1);
		tick(8);
		chk(16'(k1), 16'h0);
		for (j = 0; j < n; j++) begin
			tick(16);
			chk(16'(k1), 16'(c.transmit_data_field[(b + (c.msb_first ? -j : j)) & 15]));
		end
		tick(16);
		chk(16'(k1), 16'h1);
		wait_irq();
		tick(2);
		chk(16'(k1), 16'h1);
		c.serial_pin_enable = 1'b0;
		setup(16'h0);
		pulse_start();
		tick(3);
		chk(16'(stat.clock_active_flag), 16'h0);
		chk({14'h0, k1e, k2e}, 16'h3);
		give_verdict();
	end
endmodule : mmsi_top_test
